// file: hw/svca_admit.sv
`default_nettype none
module svca_admit
  import svca_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // incoming commands from the serial receiver or program sequencer
  input wire logic CMD_VALID,
  input wire svca_req_t CMD_REQ,
  // device state from the motion and memory engines
  input wire logic MOTION_ACTIVE,
  input wire logic PROG_ACTIVE,
  input wire logic NVM_ACTIVE,
  input wire logic EXEC_ACTIVE,
  input wire logic NVM_LOAD_DONE,
  // answer to the host
  output logic RSP_VALID,
  output svca_rsp_t RSP_CODE,
  // dispatch
  output logic EXEC_VALID,
  output svca_exec_t EXEC_CMD,
  output logic STORE_VALID,
  output svca_exec_t STORE_CMD,
  output logic SEIZE,
  output logic PROG_RUN,
  output logic NVM_STORE,
  output logic NVM_LOAD
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0] ctrl;
  logic run_req;
  logic store_req;
  logic load_req;
  logic mt_en;
  logic dl_mode;
  logic [1:0] thread_sel;
  logic [31:0] param_val;
  logic param_ok;
  svca_rsp_t decide;
  svca_exec_t disp;
  svca_state_t state_reg;
  svca_state_t state_next;
  svca_exec_t defer_reg;
  logic loaded_reg;
  logic [CNT_W-1:0] acnt_reg;
  logic [CNT_W-1:0] ncnt_reg;
  logic [7:0] last_num_reg;
  svca_rsp_t last_rsp_reg;
  logic take;
  logic release_defer;
  logic [31:0] stat_word;

  assign mt_en = ctrl[SVCA_CTRL_MT];
  assign dl_mode = ctrl[SVCA_CTRL_DL];
  assign thread_sel = ctrl[SVCA_CTRL_THR +: 2];

  // ----------------------------------------------------------------
  // register bus and parameter widening
  // ----------------------------------------------------------------
  svca_apb u_apb (
    .clk(CLK),
    .rst(RST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .ctrl(ctrl),
    .run_req(run_req),
    .store_req(store_req),
    .load_req(load_req),
    .stat_word(stat_word),
    .acnt_word({{(32 - CNT_W){1'b0}}, acnt_reg}),
    .ncnt_word({{(32 - CNT_W){1'b0}}, ncnt_reg}),
    .last_word({21'h000000, last_rsp_reg, last_num_reg})
  );

  svca_param u_param (
    .ptype(CMD_REQ.ptype),
    .raw(CMD_REQ.param),
    .value(param_val),
    .in_range(param_ok)
  );

  assign stat_word = {26'h0000000, EXEC_ACTIVE, (state_reg == SVCA_ST_DEFER),
                      loaded_reg, NVM_ACTIVE, PROG_ACTIVE, MOTION_ACTIVE};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_prog_num(input logic [7:0] num);
    return num >= SVCA_PROG_MIN;
  endfunction

  function automatic logic is_prog_cls(input svca_cls_t cls);
    return (cls == SVCA_CLS_D) || (cls == SVCA_CLS_E);
  endfunction

  function automatic logic [1:0] pick_thread(input logic [1:0] sel);
    return (sel == 2'b00) ? SVCA_THR_ONE : sel;
  endfunction

  // ----------------------------------------------------------------
  // admission decision
  // ----------------------------------------------------------------
  // single decision over flags
  always_comb begin
    decide = SVCA_RSP_ACK;
    if (is_prog_num(CMD_REQ.num) != is_prog_cls(CMD_REQ.cls)) begin
      decide = SVCA_RSP_NAK_BAD;
    end else if (CMD_REQ.from_prog && !is_prog_cls(CMD_REQ.cls)) begin
      // host-only classes never come out of a program
      decide = SVCA_RSP_NAK_BAD;
    end else if (!param_ok) begin
      decide = SVCA_RSP_NAK_BAD;
    end else if (CMD_REQ.is_seize && !is_prog_cls(CMD_REQ.cls)) begin
      decide = SVCA_RSP_ACK;
    end else begin
      case (CMD_REQ.cls)
        SVCA_CLS_A: decide = SVCA_RSP_ACK;
        SVCA_CLS_B: begin
          if (PROG_ACTIVE || NVM_ACTIVE) begin
            decide = SVCA_RSP_NAK_BUSY;
          end else if (MOTION_ACTIVE && !mt_en) begin
            decide = SVCA_RSP_NAK_BUSY;
          end else begin
            decide = SVCA_RSP_ACK;
          end
        end
        SVCA_CLS_C: begin
          if (MOTION_ACTIVE || PROG_ACTIVE || !loaded_reg) begin
            decide = SVCA_RSP_NAK_BUSY;
          end else begin
            decide = SVCA_RSP_ACK;
          end
        end
        // class F in any motor state
        SVCA_CLS_F: decide = SVCA_RSP_ACK;
        SVCA_CLS_D, SVCA_CLS_E: begin
          if (CMD_REQ.from_prog) begin
            // the sequencer owns the buffer; only motion moves may wait
            if (CMD_REQ.is_motion && MOTION_ACTIVE) begin
              decide = (state_reg == SVCA_ST_DEFER) ? SVCA_RSP_NAK_BUSY : SVCA_RSP_DEFER;
            end else begin
              decide = SVCA_RSP_ACK;
            end
          end else if (dl_mode) begin
            // buffer busy during load or store
            decide = NVM_ACTIVE ? SVCA_RSP_NAK_BUSY : SVCA_RSP_STORED;
          end else if (PROG_ACTIVE || NVM_ACTIVE || EXEC_ACTIVE ||
                       state_reg == SVCA_ST_DEFER) begin
            decide = SVCA_RSP_NAK_BUSY;
          end else if (MOTION_ACTIVE) begin
            if (!mt_en) begin
              decide = SVCA_RSP_NAK_BUSY;
            end else if (CMD_REQ.cls == SVCA_CLS_D && CMD_REQ.is_motion) begin
              decide = SVCA_RSP_DEFER;
            end else begin
              decide = SVCA_RSP_ACK;
            end
          end else begin
            decide = SVCA_RSP_ACK;
          end
        end
        default: decide = SVCA_RSP_NAK_BAD;
      endcase
    end
  end

  // every parameter is present, so one word per request suffices
  assign take = CMD_VALID;
  assign disp = '{num: CMD_REQ.num, thread: pick_thread(thread_sel), param: param_val};
  assign release_defer = (state_reg == SVCA_ST_DEFER) && !MOTION_ACTIVE;

  // ----------------------------------------------------------------
  // deferral state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SVCA_ST_IDLE: begin
        if (take && decide == SVCA_RSP_DEFER) begin
          state_next = SVCA_ST_DEFER;
        end
      end
      SVCA_ST_DEFER: begin
        if (!MOTION_ACTIVE) begin
          state_next = SVCA_ST_IDLE;
        end
      end
      default: state_next = SVCA_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= SVCA_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      defer_reg <= '0;
    end else if (take && decide == SVCA_RSP_DEFER && state_reg == SVCA_ST_IDLE) begin
      defer_reg <= disp;
    end
  end

  // ----------------------------------------------------------------
  // answer and dispatch
  // ----------------------------------------------------------------
  // busy naks answered here too
  always_ff @(posedge CLK) begin
    if (RST) begin
      RSP_VALID <= 1'b0;
      RSP_CODE <= SVCA_RSP_ACK;
    end else begin
      RSP_VALID <= take;
      if (take) begin
        RSP_CODE <= decide;
      end
    end
  end

  // a released move wins the dispatch port; a new immediate in that cycle
  // is still answered but its execute pulse is dropped and comes back
  // only by the host retrying, which is why the release is checked first
  always_ff @(posedge CLK) begin
    if (RST) begin
      EXEC_VALID <= 1'b0;
      EXEC_CMD <= '0;
    end else if (release_defer) begin
      EXEC_VALID <= 1'b1;
      EXEC_CMD <= defer_reg;
    end else if (take && decide == SVCA_RSP_ACK) begin
      EXEC_VALID <= 1'b1;
      EXEC_CMD <= disp;
    end else begin
      EXEC_VALID <= 1'b0;
    end
  end

  // host program commands pass through the buffer
  always_ff @(posedge CLK) begin
    if (RST) begin
      STORE_VALID <= 1'b0;
      STORE_CMD <= '0;
    end else begin
      STORE_VALID <= take && (decide == SVCA_RSP_STORED ||
                     (decide == SVCA_RSP_ACK && is_prog_cls(CMD_REQ.cls) &&
                      !CMD_REQ.from_prog));
      if (take) begin
        STORE_CMD <= disp;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SEIZE <= 1'b0;
    end else begin
      SEIZE <= take && CMD_REQ.is_seize && decide == SVCA_RSP_ACK &&
               !is_prog_cls(CMD_REQ.cls);
    end
  end

  // ----------------------------------------------------------------
  // program buffer bookkeeping
  // ----------------------------------------------------------------
  // loaded flag; set beats clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      loaded_reg <= 1'b0;
    end else if (NVM_LOAD_DONE || (take && decide == SVCA_RSP_STORED)) begin
      loaded_reg <= 1'b1;
    end else if (take && CMD_REQ.is_seize && decide == SVCA_RSP_ACK &&
                 !is_prog_cls(CMD_REQ.cls)) begin
      loaded_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PROG_RUN <= 1'b0;
      NVM_STORE <= 1'b0;
      NVM_LOAD <= 1'b0;
    end else begin
      PROG_RUN <= run_req && loaded_reg && !PROG_ACTIVE && !MOTION_ACTIVE && !NVM_ACTIVE;
      NVM_STORE <= store_req && loaded_reg && !NVM_ACTIVE && !PROG_ACTIVE;
      NVM_LOAD <= load_req && !NVM_ACTIVE && !PROG_ACTIVE;
    end
  end

  // ----------------------------------------------------------------
  // statistics
  // ----------------------------------------------------------------
  // counters wrap; software compares deltas
  always_ff @(posedge CLK) begin
    if (RST) begin
      acnt_reg <= '0;
      ncnt_reg <= '0;
    end else if (take) begin
      if (decide == SVCA_RSP_NAK_BUSY || decide == SVCA_RSP_NAK_BAD) begin
        ncnt_reg <= ncnt_reg + 1'b1;
      end else begin
        acnt_reg <= acnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      last_num_reg <= 8'h00;
      last_rsp_reg <= SVCA_RSP_ACK;
    end else if (take) begin
      last_num_reg <= CMD_REQ.num;
      last_rsp_reg <= decide;
    end
  end
endmodule
`default_nettype wire

// file: hw/svca_pkg.sv
`default_nettype none
package svca_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SVCA_OFF_CTRL = 8'h00;
  localparam logic [7:0] SVCA_OFF_STAT = 8'h04;
  localparam logic [7:0] SVCA_OFF_ACNT = 8'h08;
  localparam logic [7:0] SVCA_OFF_NCNT = 8'h0C;
  localparam logic [7:0] SVCA_OFF_LAST = 8'h10;
  // control register fields
  localparam int SVCA_CTRL_MT = 0;
  localparam int SVCA_CTRL_DL = 1;
  localparam int SVCA_CTRL_THR = 2;
  localparam int SVCA_CTRL_RUN = 4;
  localparam int SVCA_CTRL_STORE = 5;
  localparam int SVCA_CTRL_LOAD = 6;
  localparam logic [3:0] SVCA_CTRL_RESET = 4'h4;
  // status register fields
  localparam int SVCA_STAT_MOTION = 0;
  localparam int SVCA_STAT_PROG = 1;
  localparam int SVCA_STAT_NVM = 2;
  localparam int SVCA_STAT_LOADED = 3;
  localparam int SVCA_STAT_DEFER = 4;
  localparam int SVCA_STAT_EXEC = 5;
  // command numbering
  localparam logic [7:0] SVCA_PROG_MIN = 8'h40;
  localparam logic [1:0] SVCA_THR_ONE = 2'h1;

  typedef enum logic [2:0] {
    SVCA_CLS_A = 3'b000, SVCA_CLS_B = 3'b001, SVCA_CLS_C = 3'b010,
    SVCA_CLS_D = 3'b011, SVCA_CLS_E = 3'b100, SVCA_CLS_F = 3'b101
  } svca_cls_t;

  typedef enum logic [2:0] {
    SVCA_RSP_ACK = 3'b000, SVCA_RSP_STORED = 3'b001, SVCA_RSP_DEFER = 3'b010,
    SVCA_RSP_NAK_BUSY = 3'b011, SVCA_RSP_NAK_BAD = 3'b100
  } svca_rsp_t;

  typedef enum logic [1:0] {
    SVCA_UNSIGNED_WORD_PARAM = 2'b00, SVCA_SIGNED_WORD_PARAM = 2'b01,
    SVCA_UNSIGNED_HALF_PARAM = 2'b10, SVCA_SIGNED_HALF_PARAM = 2'b11
  } svca_ptype_t;

  typedef enum logic [1:0] {
    SVCA_ST_IDLE = 2'b00, SVCA_ST_DEFER = 2'b01
  } svca_state_t;

  typedef struct packed {
    logic [7:0] num;
    svca_cls_t cls;
    logic from_prog;
    logic is_motion;
    logic is_seize;
    svca_ptype_t ptype;
    logic [31:0] param;
  } svca_req_t;

  typedef struct packed {
    logic [7:0] num;
    logic [1:0] thread;
    logic [31:0] param;
  } svca_exec_t;
endpackage
`default_nettype wire

// file: hw/svca_param.sv
`default_nettype none
module svca_param
  import svca_pkg::*;
(
  input wire svca_ptype_t ptype,
  input wire logic [31:0] raw,
  output logic [31:0] value,
  output logic in_range
);
  // ----------------------------------------------------------------
  // parameter widening
  // ----------------------------------------------------------------
  // half parameters arrive in the low 16 bits; upper bits must be clear
  always_comb begin
    value = raw;
    in_range = 1'b1;
    case (ptype)
      SVCA_UNSIGNED_WORD_PARAM: value = raw;
      SVCA_SIGNED_WORD_PARAM: value = raw;
      SVCA_UNSIGNED_HALF_PARAM: begin
        value = {16'h0000, raw[15:0]};
        in_range = (raw[31:16] == 16'h0000);
      end
      SVCA_SIGNED_HALF_PARAM: begin
        value = {{16{raw[15]}}, raw[15:0]};
        in_range = (raw[31:16] == 16'h0000);
      end
      default: in_range = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: hw/svca_apb.sv
`default_nettype none
module svca_apb
  import svca_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register contents
  output logic [3:0] ctrl,
  output logic run_req,
  output logic store_req,
  output logic load_req,
  input wire logic [31:0] stat_word,
  input wire logic [31:0] acnt_word,
  input wire logic [31:0] ncnt_word,
  input wire logic [31:0] last_word
);
  logic [3:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic mapped;
  logic wr_now;

  assign mapped = (paddr == SVCA_OFF_CTRL) || (paddr == SVCA_OFF_STAT) ||
                  (paddr == SVCA_OFF_ACNT) || (paddr == SVCA_OFF_NCNT) ||
                  (paddr == SVCA_OFF_LAST);
  assign wr_now = psel && penable && pwrite && (paddr == SVCA_OFF_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_reg;
  assign prdata = rdata_reg;
  assign ctrl = ctrl_reg;
  // start bits are write-one pulses and read back as zero
  assign run_req = wr_now && pwdata[SVCA_CTRL_RUN];
  assign store_req = wr_now && pwdata[SVCA_CTRL_STORE];
  assign load_req = wr_now && pwdata[SVCA_CTRL_LOAD];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= SVCA_CTRL_RESET;
    end else if (wr_now) begin
      ctrl_reg <= pwdata[3:0];
    end
  end

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else if (psel && !penable) begin
      err_reg <= !mapped;
      case (paddr)
        SVCA_OFF_CTRL: rdata_reg <= {28'h0000000, ctrl_reg};
        SVCA_OFF_STAT: rdata_reg <= stat_word;
        SVCA_OFF_ACNT: rdata_reg <= acnt_word;
        SVCA_OFF_NCNT: rdata_reg <= ncnt_word;
        SVCA_OFF_LAST: rdata_reg <= last_word;
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/svca_host_model.sv
`default_nettype none
module svca_host_model
  import svca_pkg::*;
(
  // clock
  input wire logic clk,
  // from the bench
  input wire logic send,
  input wire svca_req_t req,
  // command stream into the block
  output logic cmd_valid,
  output svca_req_t cmd_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_req = '0;
  end
  always @(posedge clk) begin
    cmd_valid <= send;
    // outside a frame the fields churn, so a stale word never looks valid
    cmd_req <= send ? req : ~cmd_req;
  end
endmodule
`default_nettype wire

// file: tb/svca_admit_properties.sv
`default_nettype none
module svca_admit_properties
  import svca_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // command side
  input wire logic CMD_VALID,
  input wire svca_req_t CMD_REQ,
  input wire logic MOTION_ACTIVE,
  input wire logic PROG_ACTIVE,
  input wire logic NVM_ACTIVE,
  // answers
  input wire logic RSP_VALID,
  input wire svca_rsp_t RSP_CODE,
  input wire logic STORE_VALID,
  input wire logic SEIZE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host, imm;
  // host command whose parameter fits its declared width
  assign host = CMD_VALID && !CMD_REQ.from_prog && !(CMD_REQ.ptype[1] && |CMD_REQ.param[31:16]);
  assign imm = host && CMD_REQ.num < SVCA_PROG_MIN;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  answer_timing_a:
    assert property (CMD_VALID |=> RSP_VALID) else $error("no answer");
  class_a_ack_a:
    assert property (imm && CMD_REQ.cls == SVCA_CLS_A |=> RSP_CODE == SVCA_RSP_ACK && !STORE_VALID)
    else $error("class A refused");
  class_b_busy_a:
    assert property (imm && CMD_REQ.cls == SVCA_CLS_B && (PROG_ACTIVE || NVM_ACTIVE)
      |=> RSP_CODE == SVCA_RSP_NAK_BUSY) else $error("class B not busy");
  class_c_busy_a:
    assert property (imm && CMD_REQ.cls == SVCA_CLS_C && (MOTION_ACTIVE || PROG_ACTIVE)
      |=> RSP_CODE == SVCA_RSP_NAK_BUSY) else $error("class C not busy");
  class_f_ack_a:
    assert property (imm && CMD_REQ.cls == SVCA_CLS_F |=> RSP_CODE == SVCA_RSP_ACK && !STORE_VALID)
    else $error("class F refused");
  number_check_a:
    assert property (CMD_VALID && CMD_REQ.num >= SVCA_PROG_MIN
      && !(CMD_REQ.cls inside {SVCA_CLS_D, SVCA_CLS_E}) |=> RSP_CODE == SVCA_RSP_NAK_BAD)
    else $error("bad number accepted");
  busy_nak_a:
    assert property (host && CMD_REQ.num >= SVCA_PROG_MIN && PROG_ACTIVE
      && CMD_REQ.cls inside {SVCA_CLS_D, SVCA_CLS_E}
      |=> RSP_CODE inside {SVCA_RSP_NAK_BUSY, SVCA_RSP_STORED}) else $error("ran during program");
  seize_ack_a:
    assert property (imm && CMD_REQ.cls == SVCA_CLS_A && CMD_REQ.is_seize
      |=> SEIZE && RSP_CODE == SVCA_RSP_ACK) else $error("seize lost");
  store_answer_a:
    assert property (STORE_VALID |-> RSP_VALID && RSP_CODE inside {SVCA_RSP_ACK, SVCA_RSP_STORED})
    else $error("store without accept");
  code_hold_a:
    assert property (!CMD_VALID |=> $stable(RSP_CODE)) else $error("code changed idle");
endmodule
bind svca_admit svca_admit_properties #(.CNT_W(CNT_W)) chk (.CLK(CLK), .RST(RST),
  .CMD_VALID(CMD_VALID), .CMD_REQ(CMD_REQ), .MOTION_ACTIVE(MOTION_ACTIVE),
  .PROG_ACTIVE(PROG_ACTIVE), .NVM_ACTIVE(NVM_ACTIVE), .RSP_VALID(RSP_VALID),
  .RSP_CODE(RSP_CODE), .STORE_VALID(STORE_VALID), .SEIZE(SEIZE));
`default_nettype wire

// file: tb/svca_admit_tb.sv
`default_nettype none
module svca_admit_tb import svca_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // row: ctrl, class, number, {prog,seize,motion}, {ptype,param}, {exec,mot,prog,nvm}, code
  typedef struct packed {
    logic [3:0] k, c;
    logic [7:0] n;
    logic [3:0] f, q, s, e;
  } svca_tb_row_t;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, go, err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic CMD_VALID, MOTION_ACTIVE, PROG_ACTIVE, NVM_ACTIVE, EXEC_ACTIVE, NVM_LOAD_DONE;
  logic RSP_VALID, EXEC_VALID, STORE_VALID, SEIZE, PROG_RUN, NVM_STORE, NVM_LOAD;
  svca_req_t CMD_REQ, hreq;
  svca_rsp_t RSP_CODE;
  svca_exec_t EXEC_CMD, STORE_CMD;
  int errors, checks, cyc, run_n, store_n, load_n, w, acc_n, nak_n;
  logic [31:0] pv[4] = '{32'h0, 32'h0001_0000, 32'h0000_FFFF, 32'hFFFF_FFFF};
  svca_tb_row_t rows[32] = '{
    32'h4_0_01_0_0_0_0, 32'h4_0_01_0_0_7_0, 32'h4_1_02_0_0_0_0, 32'h4_1_02_0_0_4_3,
    32'h4_1_02_0_0_1_3, 32'h4_2_03_0_0_0_3, 32'h4_3_40_0_0_0_0, 32'h4_3_40_0_0_2_3,
    32'h4_4_FF_0_0_4_3, 32'h4_4_FF_0_0_0_0, 32'h4_5_04_0_0_4_0, 32'h4_0_40_0_0_0_4,
    32'h4_3_3F_0_0_0_4, 32'h4_0_01_8_0_0_4, 32'h4_0_01_0_9_0_4, 32'h4_0_01_0_E_0_0,
    32'h4_0_01_0_7_0_0, 32'h4_3_50_8_0_2_0, 32'h4_0_05_4_0_7_0, 32'h4_3_40_0_0_8_3,
    32'h5_1_02_0_0_4_0, 32'h5_1_02_0_0_6_3, 32'h9_4_FF_0_0_4_0, 32'hD_3_40_0_0_4_0,
    32'hD_3_40_0_0_2_3, 32'h6_3_40_0_0_0_1, 32'h6_4_FF_0_0_0_1, 32'h6_3_40_0_0_1_3,
    32'h6_0_01_0_0_0_0, 32'h6_5_04_0_0_4_0, 32'h4_2_03_0_0_0_0, 32'h4_2_03_0_0_2_3};

  svca_admit dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CMD_VALID(CMD_VALID), .CMD_REQ(CMD_REQ), .MOTION_ACTIVE(MOTION_ACTIVE),
    .PROG_ACTIVE(PROG_ACTIVE), .NVM_ACTIVE(NVM_ACTIVE), .EXEC_ACTIVE(EXEC_ACTIVE),
    .NVM_LOAD_DONE(NVM_LOAD_DONE), .RSP_VALID(RSP_VALID), .RSP_CODE(RSP_CODE),
    .EXEC_VALID(EXEC_VALID), .EXEC_CMD(EXEC_CMD), .STORE_VALID(STORE_VALID),
    .STORE_CMD(STORE_CMD), .SEIZE(SEIZE), .PROG_RUN(PROG_RUN), .NVM_STORE(NVM_STORE),
    .NVM_LOAD(NVM_LOAD));
  svca_host_model host (.clk(CLK), .send(go), .req(hreq), .cmd_valid(CMD_VALID),
    .cmd_req(CMD_REQ));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    run_n <= run_n + PROG_RUN;
    store_n <= store_n + NVM_STORE;
    load_n <= load_n + NVM_LOAD;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // the transfer ends at the edge that sees the slave ready; data taken there
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic ctl(input logic [7:0] d, input logic [3:0] st);
    @(posedge CLK);
    {EXEC_ACTIVE, MOTION_ACTIVE, PROG_ACTIVE, NVM_ACTIVE} <= st;
    apb(1'b1, SVCA_OFF_CTRL, {24'h0, d});
  endtask

  task automatic run_row(input svca_tb_row_t r);
    svca_req_t rq;
    svca_rsp_t ex;
    logic [31:0] p;
    logic [1:0] th;
    logic de;
    rq = '0;
    rq.num = r.n;
    rq.cls = svca_cls_t'(r.c[2:0]);
    {rq.from_prog, rq.is_seize, rq.is_motion} = r.f[3:1];
    rq.ptype = svca_ptype_t'(r.q[3:2]);
    p = pv[r.q[1:0]];
    rq.param = p;
    ex = svca_rsp_t'(r.e[2:0]);
    if (ex inside {SVCA_RSP_NAK_BUSY, SVCA_RSP_NAK_BAD}) begin
      nak_n++;
    end else begin
      acc_n++;
    end
    th = (r.k[3:2] == 2'h0) ? SVCA_THR_ONE : r.k[3:2];
    de = (r.c == 4'h3) || (r.c == 4'h4);
    if (r.q[3:2] == 2'h3) p = {{16{p[15]}}, p[15:0]};
    ctl({4'h0, r.k}, r.s);
    @(posedge CLK);
    hreq <= rq;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    @(posedge CLK);
    #1;
    chk(RSP_VALID, 1'b1, "rsp_valid");
    chk(RSP_CODE, ex, "rsp_code");
    chk(EXEC_VALID, ex == SVCA_RSP_ACK, "exec_valid");
    chk(SEIZE, r.f[2] && ex == SVCA_RSP_ACK, "seize");
    chk(STORE_VALID, ex == SVCA_RSP_STORED || (!r.f[3] && de && ex == SVCA_RSP_ACK), "store");
    if (ex == SVCA_RSP_STORED) chk(STORE_CMD.num, r.n, "store_num");
    if (ex == SVCA_RSP_ACK) begin
      chk(EXEC_CMD.num, r.n, "exec_num");
      chk(EXEC_CMD.param, p, "exec_param");
      if (de) chk(EXEC_CMD.thread, th, "thread");
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, go, NVM_LOAD_DONE} = '0;
    {EXEC_ACTIVE, MOTION_ACTIVE, PROG_ACTIVE, NVM_ACTIVE} = '0;
    PADDR = '0;
    PWDATA = '0;
    hreq = '0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, SVCA_OFF_CTRL, '0);
    chk(rd, {28'h0, SVCA_CTRL_RESET}, "ctrl_rst");
    apb(1'b0, SVCA_OFF_STAT, '0);
    chk(rd, 32'h0, "stat_rst");
    apb(1'b0, 8'h20, '0);
    chk(err, 1'b1, "unmapped_err");
    chk(rd, 32'h0, "unmapped_rd");
    foreach (rows[i]) run_row(rows[i]);
    // run is held off by motion, load by a busy memory
    ctl(8'h14, 4'h4);
    ctl(8'h14, 4'h0);
    ctl(8'h24, 4'h0);
    ctl(8'h44, 4'h1);
    ctl(8'h44, 4'h0);
    repeat (2) @(posedge CLK);
    chk(run_n, 1, "prog_run");
    chk(store_n, 1, "nvm_store");
    chk(load_n, 1, "nvm_load");
    // seize empties the buffer; memory refill makes class C legal again
    run_row(32'h4_0_05_4_0_0_0);
    run_row(32'h4_2_03_0_0_0_3);
    @(posedge CLK);
    NVM_LOAD_DONE <= 1'b1;
    @(posedge CLK);
    NVM_LOAD_DONE <= 1'b0;
    run_row(32'h4_2_03_0_0_0_0);
    // deferred move, a busy refusal meanwhile, release when motion ends
    run_row(32'h9_3_41_2_0_4_2);
    run_row(32'h9_3_42_0_0_4_3);
    @(posedge CLK);
    MOTION_ACTIVE <= 1'b0;
    w = 0;
    #1;
    while (EXEC_VALID !== 1'b1 && w < 4) begin
      @(posedge CLK);
      #1;
      w++;
    end
    chk(EXEC_VALID, 1'b1, "defer_exec");
    chk(EXEC_CMD.num, 8'h41, "defer_num");
    chk(EXEC_CMD.thread, 2'h2, "defer_thread");
    // statistics and status after the whole command run
    apb(1'b0, SVCA_OFF_ACNT, '0);
    chk(rd, acc_n, "acc_cnt");
    apb(1'b0, SVCA_OFF_NCNT, '0);
    chk(rd, nak_n, "nak_cnt");
    apb(1'b0, SVCA_OFF_LAST, '0);
    chk(rd, {21'h0, SVCA_RSP_NAK_BUSY, 8'h42}, "last_cmd");
    apb(1'b0, SVCA_OFF_STAT, '0);
    chk(rd, 32'h0000_0001 << SVCA_STAT_LOADED, "stat_loaded");
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, SVCA_OFF_CTRL, '0);
    chk(rd, {28'h0, SVCA_CTRL_RESET}, "ctrl_rst2");
    apb(1'b0, SVCA_OFF_NCNT, '0);
    chk(rd, 32'h0, "nak_rst2");
    end_of_test();
  end
endmodule
`default_nettype wire
